// ---- wpu_pkg.sv ----
// Purpose: Shared constants and types for the register write-protect unit
// Assumes: AXI4-Lite with 32-bit data, byte addresses are four times the register index
// Notes: Protected registers are 8 bits wide and sit in the low byte of their word
package wpu_pkg;

  // Bus geometry
  localparam int AXI_ADDR_W = 8;
  localparam int IDX_W = 6;
  localparam int REG_W = 8;

  // Write-protect control register
  localparam logic [IDX_W-1:0] WPC_IDX = 6'h0A;
  localparam logic [REG_W-1:0] WPC_RESET = 8'h00;
  localparam logic [REG_W-1:0] WPC_RW_MASK = 8'h7F;
  localparam int WPC_CLK_BIT = 0;
  localparam int WPC_MODE_BIT = 1;
  localparam int WPC_VOLT_BIT = 3;

  // Protected register indices, clock group first
  localparam logic [IDX_W-1:0] CLOCK_MODE_REG_A_IDX = 6'h10;
  localparam logic [IDX_W-1:0] CLOCK_MODE_REG_B_IDX = 6'h11;
  localparam logic [IDX_W-1:0] CLOCK_MODE_REG_C_IDX = 6'h12;
  localparam logic [IDX_W-1:0] OSC_STOP_DETECT_REG_IDX = 6'h13;
  localparam logic [IDX_W-1:0] HS_OSC_CTRL_A_IDX = 6'h14;
  localparam logic [IDX_W-1:0] HS_OSC_CTRL_B_IDX = 6'h15;
  localparam logic [IDX_W-1:0] HS_OSC_CTRL_C_IDX = 6'h16;
  localparam logic [IDX_W-1:0] HS_OSC_CTRL_D_IDX = 6'h17;
  localparam logic [IDX_W-1:0] PROCESSOR_MODE_REG_A_IDX = 6'h18;
  localparam logic [IDX_W-1:0] PROCESSOR_MODE_REG_B_IDX = 6'h19;
  localparam logic [IDX_W-1:0] REF_VOLTAGE_CTRL_IDX = 6'h1A;
  localparam logic [IDX_W-1:0] VOLT_DETECT_CTRL_IDX = 6'h1B;
  localparam logic [IDX_W-1:0] VOLT_DETECT_LEVEL_SEL_IDX = 6'h1C;
  localparam logic [IDX_W-1:0] VOLT_MONITOR_CTRL_A_IDX = 6'h1D;
  localparam logic [IDX_W-1:0] VOLT_MONITOR_CTRL_B_IDX = 6'h1E;
  localparam logic [IDX_W-1:0] VOLT_MONITOR_CTRL_C_IDX = 6'h1F;
  localparam int PROT_NUM = 16;
  localparam logic [REG_W-1:0] PROT_RESET = 8'h00;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Protection group of a register index
  typedef enum logic [1:0] {
    WPU_GRP_NONE = 2'b00,
    WPU_GRP_CLK = 2'b01,
    WPU_GRP_MODE = 2'b10,
    WPU_GRP_VOLT = 2'b11
  } wpu_grp_t;

  // Group decode, shared by the write gate and the bus decoder
  function automatic wpu_grp_t wpu_group(input logic [IDX_W-1:0] idx);
    wpu_grp_t grp;
    grp = WPU_GRP_NONE;
    if (idx >= CLOCK_MODE_REG_A_IDX && idx <= HS_OSC_CTRL_D_IDX) begin
      grp = WPU_GRP_CLK;
    end else if (idx >= PROCESSOR_MODE_REG_A_IDX && idx <= PROCESSOR_MODE_REG_B_IDX) begin
      grp = WPU_GRP_MODE;
    end else if (idx >= REF_VOLTAGE_CTRL_IDX && idx <= VOLT_MONITOR_CTRL_C_IDX) begin
      grp = WPU_GRP_VOLT;
    end
    return grp;
  endfunction

endpackage

// ---- wpu_bank_if.sv ----
// Purpose: Carrier between the bus front end and the protected register bank
// Assumes: One clock domain, write and read index in register-index units
// Notes: Read path is combinational through the bank
`timescale 1ns/100ps
interface wpu_bank_if;
  import wpu_pkg::*;
  logic wr_en;
  logic [IDX_W-1:0] wr_idx;
  logic [REG_W-1:0] wr_data;
  logic [IDX_W-1:0] rd_idx;
  logic [REG_W-1:0] rd_data;
  logic [2:0] grp_we;

  modport ctrl (output wr_en, wr_idx, wr_data, rd_idx, grp_we, input rd_data);
  modport bank (input wr_en, wr_idx, wr_data, rd_idx, grp_we, output rd_data);
endinterface

// ---- wpu_bank.sv ----
// Purpose: Protected register bank with per-group write gating
// Assumes: Write requests arrive already decoded to a protected index
// Notes: Reads ignore the group enables entirely
`timescale 1ns/100ps
module wpu_bank #(
  parameter logic [wpu_pkg::REG_W-1:0] RESET_VAL = wpu_pkg::PROT_RESET
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Front end
  wpu_bank_if.bank bus,
  // Register contents
  output logic [wpu_pkg::PROT_NUM*wpu_pkg::REG_W-1:0] regs_o
);
  import wpu_pkg::*;

  logic [REG_W-1:0] regs_ff [PROT_NUM];
  wpu_grp_t wr_grp;
  logic wr_allowed;
  logic [IDX_W-1:0] wr_rel;
  logic [IDX_W-1:0] rd_rel;

  // Gate each write by the enable of its own group
  assign wr_grp = wpu_group(bus.wr_idx);
  assign wr_allowed = (wr_grp == WPU_GRP_CLK && bus.grp_we[0]) ||
                      (wr_grp == WPU_GRP_MODE && bus.grp_we[1]) ||
                      (wr_grp == WPU_GRP_VOLT && bus.grp_we[2]);
  assign wr_rel = bus.wr_idx - CLOCK_MODE_REG_A_IDX;
  assign rd_rel = bus.rd_idx - CLOCK_MODE_REG_A_IDX;

  // Unprotected read, out of range reads give zero
  assign bus.rd_data = (wpu_group(bus.rd_idx) != WPU_GRP_NONE) ? regs_ff[rd_rel[3:0]] :
                       8'h00;

  // Blocked writes simply leave the word alone
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < PROT_NUM; i++) begin
      if (srst_i) begin
        regs_ff[i] <= RESET_VAL;
      end else if (bus.wr_en && wr_allowed && wr_rel[3:0] == 4'(i)) begin
        regs_ff[i] <= bus.wr_data;
      end
    end
  end

  // Flatten for the protected consumers
  always_comb begin
    for (int i = 0; i < PROT_NUM; i++) begin
      regs_o[i*REG_W +: REG_W] = regs_ff[i];
    end
  end

endmodule // wpu_bank

// ---- wpu_top.sv ----
// Purpose: Register write-protect unit, AXI4-Lite slave with protected bank
// Assumes: 20 MHz MCLK_I, synchronous active-high SRST_I, one write and one read at a time
// Notes: Only byte lane 0 carries register data; upper data bits read as zero
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/100ps
module wpu_top (
  // Clock and reset
  input wire logic MCLK_I,
  input wire logic SRST_I,
  // AXI4-Lite write address
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [wpu_pkg::AXI_ADDR_W-1:0] S_AXI_AWADDR_I,
  input wire logic [2:0] S_AXI_AWPROT_I,
  // AXI4-Lite write data
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  // AXI4-Lite write response
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  output logic [1:0] S_AXI_BRESP_O,
  // AXI4-Lite read address
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  input wire logic [wpu_pkg::AXI_ADDR_W-1:0] S_AXI_ARADDR_I,
  input wire logic [2:0] S_AXI_ARPROT_I,
  // AXI4-Lite read data
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  // Group enables and protected register contents
  output logic [2:0] GRP_WE_O,
  output logic [wpu_pkg::PROT_NUM*wpu_pkg::REG_W-1:0] PROT_REGS_O
);
  import wpu_pkg::*;

  wpu_bank_if bank_bus ();

  logic aw_held_ff;
  logic w_held_ff;
  logic bvalid_ff;
  logic rvalid_ff;
  logic [AXI_ADDR_W-1:0] awaddr_ff;
  logic [REG_W-1:0] wdata_ff;
  logic wlane0_ff;
  logic [1:0] bresp_ff;
  logic [1:0] rresp_ff;
  logic [31:0] rdata_ff;
  logic [REG_W-1:0] wpc_ff;
  logic [REG_W-1:0] nxt_wpc;

  // Write channels are taken independently until the response is out
  wire aw_take = S_AXI_AWVALID_I && S_AXI_AWREADY_O;
  wire w_take = S_AXI_WVALID_I && S_AXI_WREADY_O;
  wire aw_have = aw_held_ff || aw_take;
  wire w_have = w_held_ff || w_take;
  wire wr_fire = aw_have && w_have && !bvalid_ff;
  assign S_AXI_AWREADY_O = !aw_held_ff && !bvalid_ff;
  assign S_AXI_WREADY_O = !w_held_ff && !bvalid_ff;

  // Write decode from the held or the live channel
  wire [AXI_ADDR_W-1:0] wr_addr = aw_held_ff ? awaddr_ff : S_AXI_AWADDR_I;
  wire [REG_W-1:0] wr_byte = w_held_ff ? wdata_ff : S_AXI_WDATA_I[REG_W-1:0];
  wire wr_lane0 = w_held_ff ? wlane0_ff : S_AXI_WSTRB_I[0];
  wire [IDX_W-1:0] wr_idx = wr_addr[IDX_W+1:2];
  wire wr_is_wpc = (wr_idx == WPC_IDX);
  wire wr_is_prot = (wpu_group(wr_idx) != WPU_GRP_NONE);

  // Read decode
  wire ar_take = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
  wire [IDX_W-1:0] rd_idx = S_AXI_ARADDR_I[IDX_W+1:2];
  wire rd_is_wpc = (rd_idx == WPC_IDX);
  wire rd_is_prot = (wpu_group(rd_idx) != WPU_GRP_NONE);
  wire [31:0] rd_word = rd_is_wpc ? {24'h000000, wpc_ff & WPC_RW_MASK} :
                        rd_is_prot ? {24'h000000, bank_bus.rd_data} :
                        32'h00000000;
  assign S_AXI_ARREADY_O = !rvalid_ff;

  // Only a software write or SRST_I moves the enables; nothing relocks them behind its back
  assign nxt_wpc = (wr_fire && wr_is_wpc && wr_lane0) ? (wr_byte & WPC_RW_MASK) : wpc_ff;

  // Feed the bank
  assign bank_bus.wr_en = wr_fire && wr_is_prot && wr_lane0;
  assign bank_bus.wr_idx = wr_idx;
  assign bank_bus.wr_data = wr_byte;
  assign bank_bus.rd_idx = rd_idx;
  assign bank_bus.grp_we = {wpc_ff[WPC_VOLT_BIT], wpc_ff[WPC_MODE_BIT], wpc_ff[WPC_CLK_BIT]};

  // Control register
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      wpc_ff <= WPC_RESET;
    end else begin
      wpc_ff <= nxt_wpc;
    end
  end

  // Write channel holding and response
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      awaddr_ff <= '0;
      wdata_ff <= 8'h00;
      wlane0_ff <= 1'b0;
    end else begin
      aw_held_ff <= !wr_fire && aw_have;
      w_held_ff <= !wr_fire && w_have;
      if (aw_take) begin
        awaddr_ff <= S_AXI_AWADDR_I;
      end
      if (w_take) begin
        wdata_ff <= S_AXI_WDATA_I[REG_W-1:0];
        wlane0_ff <= S_AXI_WSTRB_I[0];
      end
      if (wr_fire) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= (wr_is_wpc || wr_is_prot) ? RESP_OKAY : RESP_DECERR;
      end else if (S_AXI_BREADY_I) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // Read response, data held until taken
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_word;
      rresp_ff <= (rd_is_wpc || rd_is_prot) ? RESP_OKAY : RESP_DECERR;
    end else if (S_AXI_RREADY_I) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign S_AXI_BVALID_O = bvalid_ff;
  assign S_AXI_BRESP_O = bresp_ff;
  assign S_AXI_RVALID_O = rvalid_ff;
  assign S_AXI_RDATA_O = rdata_ff;
  assign S_AXI_RRESP_O = rresp_ff;
  assign GRP_WE_O = bank_bus.grp_we;

  // Protected bank, gated per group
  wpu_bank #(
    .RESET_VAL(PROT_RESET)
  ) u_bank (
    .clk_i(MCLK_I),
    .srst_i(SRST_I),
    .bus(bank_bus.bank),
    .regs_o(PROT_REGS_O)
  );

endmodule // wpu_top

// ---- wpu_monitor.sv ----
// Purpose: Port-level checks of the write-protect unit
// Assumes: One clock domain; reset disables every check
// Notes: Lock checks watch whole group slices of the protected bank
`timescale 1ns/100ps
module wpu_monitor (
  // Clock and reset
  input wire logic MCLK_I,
  input wire logic SRST_I,
  // Bus handshakes
  input wire logic S_AXI_AWVALID_I,
  input wire logic S_AXI_AWREADY_O,
  input wire logic S_AXI_WVALID_I,
  input wire logic S_AXI_WREADY_O,
  input wire logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [1:0] S_AXI_BRESP_O,
  input wire logic S_AXI_ARVALID_I,
  input wire logic S_AXI_ARREADY_O,
  input wire logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  input wire logic [31:0] S_AXI_RDATA_O,
  // Enables and bank
  input wire logic [2:0] GRP_WE_O,
  input wire logic [127:0] PROT_REGS_O
);
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (SRST_I);
  // Answer timing and holding
  a_write_answer: assert property (S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I &&
    S_AXI_WREADY_O |=> S_AXI_BVALID_O) else $error("write not answered");
  a_b_holds: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=>
    S_AXI_BVALID_O && $stable(S_AXI_BRESP_O)) else $error("write answer dropped");
  a_read_answer: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O
    ##0 S_AXI_RDATA_O[31:8] == 24'h0) else $error("read not answered");
  a_r_holds: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I |=>
    S_AXI_RVALID_O && $stable(S_AXI_RDATA_O)) else $error("read answer dropped");
  // Enables and bank move only with a write
  a_enable_keeps: assert property (!$past(SRST_I) && $changed(GRP_WE_O)
    |-> $rose(S_AXI_BVALID_O)) else $error("enables moved without a write");
  a_bank_keeps: assert property (!$past(SRST_I) && $changed(PROT_REGS_O)
    |-> $rose(S_AXI_BVALID_O)) else $error("bank moved without a write");
  // Locked groups stay unchanged
  a_clk_locked: assert property (!GRP_WE_O[0] |=> $stable(PROT_REGS_O[63:0]))
    else $error("clock group written while locked");
  a_mode_locked: assert property (!GRP_WE_O[1] |=> $stable(PROT_REGS_O[79:64]))
    else $error("mode group written while locked");
  a_volt_locked: assert property (!GRP_WE_O[2] |=> $stable(PROT_REGS_O[127:80]))
    else $error("voltage group written while locked");
  c_write: cover property (S_AXI_BVALID_O && S_AXI_BREADY_I);
  c_read: cover property (S_AXI_RVALID_O && S_AXI_RREADY_I);
  c_all_open: cover property (GRP_WE_O == 3'h7);
endmodule // wpu_monitor

bind wpu_top wpu_monitor mon_u (.*);

// ---- register_write_protect_tb.sv ----
// Purpose: Directed bus tests of the write-protect unit
// Assumes: 20 MHz clock, one write and one read under way at a time
// Notes: Expected bank contents kept in a local array
`timescale 1ns/100ps
module register_write_protect_tb;
  import wpu_pkg::*;
  logic ck = 0, rst = 1, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic [7:0] awa = 0, ara = 0;
  logic [31:0] wdat = 0, rdat;
  logic [3:0] strb = 4'hF;
  logic awrdy, wrdy, bv, arrdy, rv;
  logic [1:0] bresp, rresp;
  logic [2:0] grp;
  logic [PROT_NUM*REG_W-1:0] prot;
  logic [7:0] expr [16] = '{default: 8'h00};
  logic [7:0] ctl [5] = '{8'h8B, 8'h01, 8'h02, 8'h08, 8'h00};
  int n_errors = 0;
  int checks = 0;
  // Protection bits tied, the unit ignores them; lane 0 strobe is driven
  wpu_top dut_u (.MCLK_I(ck), .SRST_I(rst), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awrdy),
    .S_AXI_AWADDR_I(awa), .S_AXI_AWPROT_I(3'h0), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrdy),
    .S_AXI_WDATA_I(wdat), .S_AXI_WSTRB_I(strb), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(br),
    .S_AXI_BRESP_O(bresp), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arrdy),
    .S_AXI_ARADDR_I(ara), .S_AXI_ARPROT_I(3'h0), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rr),
    .S_AXI_RDATA_O(rdat), .S_AXI_RRESP_O(rresp), .GRP_WE_O(grp), .PROT_REGS_O(prot));
  // 50 ns period
  initial begin
    forever #25 ck = ~ck;
  end
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // A wait that ran out ends the run
  task hang(input string nm);
    n_errors++;
    $display("[ERR] %s expected answer seen none", nm);
    tally_and_finish;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    @(posedge ck);
    awv <= 1'b1;
    awa <= a;
    wv <= 1'b1;
    wdat <= {24'h0, d};
    br <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge ck);
      if (awv && awrdy === 1'b1) awv <= 1'b0;
      if (wv && wrdy === 1'b1) wv <= 1'b0;
      if (bv === 1'b1) break;
    end
    br <= 1'b0;
    if (n == 40) hang("bvalid");
    chk("bresp", er, bresp);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    @(posedge ck);
    arv <= 1'b1;
    ara <= a;
    rr <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge ck);
      if (arv && arrdy === 1'b1) arv <= 1'b0;
      if (rv === 1'b1) break;
    end
    rr <= 1'b0;
    if (n == 40) hang("rvalid");
    chk("rdata", ed, rdat);
    chk("rresp", er, rresp);
  endtask
  // Enable bit position of bank entry k
  function automatic int gbit(input int k);
    return k < 8 ? 0 : (k < 10 ? 1 : 3);
  endfunction
  // Each pass opens one set of groups, writes all entries, reads all back
  initial begin
    int p;
    int k;
    repeat (5) @(posedge ck);
    rst <= 1'b0;
    rd(8'h28, 32'h0, RESP_OKAY);
    chk("grp_we", 3'h0, grp);
    chk("bank_rst", 32'h0, {31'h0, |prot});
    $display("reset test done");
    for (p = 0; p < 5; p++) begin
      wr(8'h28, ctl[p], RESP_OKAY);
      chk("grp_we", {ctl[p][3], ctl[p][1:0]}, grp);
      for (k = 0; k < 16; k++) begin
        wr(8'(64 + 4 * k), 8'(16 * p + k + 1), RESP_OKAY);
        if (ctl[p][gbit(k)]) expr[k] = 8'(16 * p + k + 1);
      end
      for (k = 0; k < 16; k++) begin
        rd(8'(64 + 4 * k), {24'h0, expr[k]}, RESP_OKAY);
        chk("bank", expr[k], prot[8*k +: 8]);
      end
      rd(8'h28, {24'h0, ctl[p] & 8'h7F}, RESP_OKAY);
      $display("pass %0d done", p);
    end
    // Lane 0 strobe low: answered, but the enables stay locked
    strb <= 4'hE;
    wr(8'h28, 8'h0B, RESP_OKAY);
    chk("grp_strb", 3'h0, grp);
    strb <= 4'hF;
    $display("strobe test done");
    // Mid-run reset relocks every group and clears the bank
    wr(8'h28, 8'h0B, RESP_OKAY);
    rst <= 1'b1;
    repeat (2) @(posedge ck);
    rst <= 1'b0;
    chk("grp_midrst", 3'h0, grp);
    chk("bank_midrst", 32'h0, {31'h0, |prot});
    rd(8'h28, 32'h0, RESP_OKAY);
    $display("midrun reset test done");
    // Unmapped place answers with a decode error
    wr(8'h00, 8'h55, RESP_DECERR);
    rd(8'h00, 32'h0, RESP_DECERR);
    $display("unmapped test done");
    tally_and_finish;
  end
endmodule // register_write_protect_tb
